// *** sim/dma_channel_control_status_asserts.sv ***
// Temporal checks on the channel's memory side and completion.
// Bound into dma_channel_control_status; sees its ports only.
`timescale 1ns/1ps
module dma_channel_control_status_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Watched ports
  input wire dma_ch_pkg::mem_req_s readReq,
  input wire dma_ch_pkg::mem_rsp_s readRsp,
  input wire dma_ch_pkg::mem_req_s writeReq,
  input wire dma_ch_pkg::mem_rsp_s writeRsp,
  input wire logic [15:0] chainTriggerOut,
  input wire logic channelIrq,
  input wire logic busy
);
  import dma_ch_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence rdFault;
    readReq.valid && readRsp.done && readRsp.err;
  endsequence
  sequence wrFault;
    writeReq.valid && writeRsp.done && writeRsp.err;
  endsequence
  issue_needs_busy_a: assert property (readReq.valid |-> busy) else $error("read issued while idle");
  read_fault_irq_a: assert property (rdFault |-> ##[1:2] channelIrq) else $error("no irq on read fault");
  read_fault_halt_a: assert property (rdFault |=> !writeReq.valid [*3]) else $error("write after read fault");
  write_fault_halt_a: assert property (wrFault |-> ##[1:2] !busy) else $error("busy after write fault");
  chain_self_off_a: assert property ($onehot0(chainTriggerOut) && !chainTriggerOut[7])
    else $error("bad chain pulse");
  chain_at_end_a: assert property (|chainTriggerOut |-> $fell(busy)) else $error("chain not at end");
  read_hold_a: assert property (readReq.valid && !readRsp.done |=> readReq.valid && $stable(readReq.addr))
    else $error("read request moved");
  write_hold_a: assert property (writeReq.valid && !writeRsp.done |=> writeReq.valid && $stable(writeReq.data))
    else $error("write request moved");
  width_match_a: assert property ($rose(writeReq.valid) |-> writeReq.size == $past(readReq.size))
    else $error("write width differs");
endmodule
bind dma_channel_control_status dma_channel_control_status_asserts dma_channel_control_status_asserts_inst (
  .ref_clk, .rst_b, .readReq, .readRsp, .writeReq, .writeRsp, .chainTriggerOut, .channelIrq, .busy);

// *** sim/mem_partner.sv ***
// Bus fabric model answering the channel's reads and writes.
// Assumes one outstanding request, held until done is seen.
`timescale 1ns/1ps
module mem_partner (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Requests and answers
  input wire dma_ch_pkg::mem_req_s readReq,
  input wire dma_ch_pkg::mem_req_s writeReq,
  output dma_ch_pkg::mem_rsp_s readRsp,
  output dma_ch_pkg::mem_rsp_s writeRsp,
  // Behaviour and observation
  input wire logic [3:0] waitCycles,
  input wire logic readFault,
  input wire logic writeFault,
  output logic [31:0] lastWrAddr,
  output logic [31:0] lastWrData
);
  import dma_ch_pkg::*;
  logic [3:0] cnt_q;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      readRsp <= '0;
      writeRsp <= '0;
    end else begin
      readRsp.done <= 1'b0;
      readRsp.err <= 1'b0;
      writeRsp.done <= 1'b0;
      writeRsp.err <= 1'b0;
      // Stale data flips so nothing latches it by luck
      readRsp.data <= ~readRsp.data;
      if ((readReq.valid && !readRsp.done) || (writeReq.valid && !writeRsp.done)) begin
        cnt_q <= (cnt_q >= waitCycles) ? 4'h0 : cnt_q + 4'h1;
        if (cnt_q >= waitCycles && readReq.valid) begin
          readRsp.done <= 1'b1;
          readRsp.err <= readFault;
          readRsp.data <= 32'h4433_2211 + readReq.addr;
        end else if (cnt_q >= waitCycles) begin
          writeRsp.done <= 1'b1;
          writeRsp.err <= writeFault;
          lastWrAddr <= writeReq.addr;
          lastWrData <= writeReq.data;
        end
      end
    end
  end
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the channel control and status block.
// Assumes the fabric model answers every request.
`timescale 1ns/1ps
module tb_top;
  import dma_ch_pkg::*;
  logic ref_clk = 1'b0, rst_b = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, sniffData, lastWrAddr, lastWrData, q;
  logic [3:0] s_axi_wstrb = 4'hf, timerRequest = '0, sniffChannel = 4'h7, waitCycles = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [58:0] peripheralDataRequest = '0;
  logic chainTriggerIn = 0, sniffEnable = 0, readFault = 0, writeFault = 0;
  logic [15:0] chainTriggerOut;
  mem_req_s readReq, writeReq;
  mem_rsp_s readRsp, writeRsp;
  logic sniffValid, preferred, channelIrq, busy;
  int errCount = 0, comparisons = 0, cyc = 0;
  integer irqs = 0, chains = 0, sniffs = 0;
  dma_channel_control_status dma_channel_control_status_inst (.ref_clk, .rst_b, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .peripheralDataRequest, .timerRequest,
    .chainTriggerIn, .chainTriggerOut, .readReq, .readRsp, .writeReq, .writeRsp, .sniffEnable,
    .sniffChannel, .sniffValid, .sniffData, .preferred, .channelIrq, .busy);
  mem_partner mem_partner_inst (.ref_clk, .rst_b, .readReq, .writeReq, .readRsp, .writeRsp,
    .waitCycles, .readFault, .writeFault, .lastWrAddr, .lastWrData);
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    irqs <= irqs + channelIrq;
    chains <= chains + chainTriggerOut[3];
    sniffs <= sniffs + sniffValid;
    if (cyc == 20000) begin
      errCount++;
      complete_run();
    end
  end
  task automatic complete_run;
    if (errCount == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errCount++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One AXI4-Lite transfer; holds each channel until taken
  task automatic bus(input bit rd, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    if (rd) begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end else begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(rd ? s_axi_rvalid : s_axi_bvalid));
    q = s_axi_rdata;
    r = rd ? s_axi_rresp : s_axi_bresp;
    s_axi_rready <= 1'b0;
    s_axi_bready <= 1'b0;
  endtask
  function automatic logic [31:0] cw(logic [5:0] pace, logic [1:0] sz, logic [3:0] nx, logic [31:0] ext);
    return ext | (pace << PACE_LSB) | (nx << NEXT_LSB) | (sz << SIZE_LSB) | 32'h1;
  endfunction
  task automatic run(input logic [31:0] ctl, cnt, ra, wa);
    bus(0, READ_ADDR_OFFSET, ra);
    bus(0, WRITE_ADDR_OFFSET, wa);
    bus(0, TRANS_COUNT_OFFSET, cnt);
    bus(0, CTRL_OFFSET, ctl);
  endtask
  task automatic settle;
    int n;
    n = 0;
    @(posedge ref_clk);
    check(busy, 1);
    while (busy !== 1'b0 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    check(n < 300, 1);
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic t_reset;
    bus(1, CTRL_OFFSET, 0);
    check(q, {8'h0, CTRL_RESET});
    bus(1, 12'h100, 0);
    check({r, q}, {RESP_SLVERR, 32'h0});
    bus(0, 12'h100, 32'hffff_ffff);
    check(r, RESP_SLVERR);
    bus(0, CTRL_OFFSET, 32'h9f00_3800);
    bus(1, CTRL_OFFSET, 0);
    check({busy, q}, {1'b0, 32'h0000_3800});
    chainTriggerIn <= 1'b1;
    @(posedge ref_clk);
    chainTriggerIn <= 1'b0;
    @(posedge ref_clk);
    check(busy, 0);
  endtask
  task automatic t_copy;
    int i0, c0;
    logic [31:0] st, mk, d;
    for (int sz = 0; sz < 3; sz++) begin
      for (int rv = 0; rv < 2; rv++) begin
        i0 = irqs;
        c0 = chains;
        st = 32'h1 << sz;
        mk = (sz == 2) ? '1 : (32'h1 << (8 << sz)) - 1;
        run(cw(PACE_ALWAYS, 2'(sz), 4'h3, (rv << REVERSE_BIT) | (rv << PRIORITY_BIT) | 32'h30), 2, 32'h1000, 32'h2000);
        check(preferred, rv);
        settle();
        d = 32'h4433_2211 + 32'h1000 + st;
        if (rv && sz == 1) d = {16'h0, d[7:0], d[15:8]};
        if (rv && sz == 2) d = {d[7:0], d[15:8], d[23:16], d[31:24]};
        check(lastWrData & mk, d & mk);
        check(lastWrAddr, 32'h2000 + st);
        bus(1, READ_ADDR_OFFSET, 0);
        check(q, 32'h1000 + 2 * st);
        check({chains - c0, irqs - i0}, {32'h1, 32'h1});
      end
    end
  endtask
  task automatic t_ring;
    for (int sel = 0; sel < 2; sel++) begin
      run(cw(PACE_ALWAYS, SIZE_WORD, 4'h7, 32'h30 | (3 << RING_SIZE_LSB) | (sel << RING_SEL_BIT)), 3, 32'h1004, 32'h2004);
      settle();
      bus(1, READ_ADDR_OFFSET, 0);
      check(q, sel ? 32'h1010 : 32'h1000);
      bus(1, WRITE_ADDR_OFFSET, 0);
      check(q, sel ? 32'h2000 : 32'h2010);
    end
    run(cw(PACE_ALWAYS, SIZE_WORD, 4'h7, 0), 2, 32'h1000, 32'h2000);
    settle();
    check(lastWrAddr, 32'h2000);
    bus(1, READ_ADDR_OFFSET, 0);
    check(q, 32'h1000);
    // Chained start while enabled and idle
    bus(0, TRANS_COUNT_OFFSET, 1);
    chainTriggerIn <= 1'b1;
    @(posedge ref_clk);
    chainTriggerIn <= 1'b0;
    settle();
  endtask
  task automatic t_pace;
    logic [5:0] codes [4] = '{6'h05, PACE_LAST_PERIPHERAL_DATA_REQUEST, PACE_TIMER0, PACE_TIMER3};
    foreach (codes[i]) begin
      run(cw(codes[i], SIZE_WORD, 4'h7, 0), 1, 32'h1000, 32'h2000);
      repeat (8) @(posedge ref_clk);
      check({busy, readReq.valid}, 2'b10);
      if (codes[i] < PACE_TIMER0) peripheralDataRequest[codes[i]] <= 1'b1;
      else timerRequest[codes[i] - PACE_TIMER0] <= 1'b1;
      settle();
      peripheralDataRequest <= '0;
      timerRequest <= '0;
    end
  endtask
  task automatic t_pause;
    waitCycles <= 4'h3;
    run(cw(PACE_ALWAYS, SIZE_WORD, 4'h7, 32'h30), 4, 32'h1000, 32'h2000);
    bus(0, CTRL_OFFSET, cw(PACE_ALWAYS, SIZE_WORD, 4'h7, 32'h30) & ~32'h1);
    repeat (20) @(posedge ref_clk);
    check({busy, readReq.valid, writeReq.valid}, 3'b100);
    bus(1, CTRL_OFFSET, 0);
    check(q[BUSY_BIT], 1);
    bus(0, CTRL_OFFSET, cw(PACE_ALWAYS, SIZE_WORD, 4'h7, 32'h30));
    settle();
    waitCycles <= 4'h0;
  endtask
  task automatic t_error;
    int i0;
    for (int k = 0; k < 2; k++) begin
      readFault <= !k;
      writeFault <= 1'(k);
      i0 = irqs;
      run(cw(PACE_ALWAYS, SIZE_WORD, 4'h7, 32'h30 | (1 << QUIET_BIT)), 3, 32'h1000, 32'h2000);
      settle();
      check(irqs - i0, 1);
      bus(1, CTRL_OFFSET, 0);
      check(q[31:29], k ? 3'b101 : 3'b110);
      bus(1, k ? WRITE_ADDR_OFFSET : READ_ADDR_OFFSET, 0);
      check(q, k ? 32'h2000 : 32'h1000);
      readFault <= 1'b0;
      writeFault <= 1'b0;
      bus(0, CTRL_OFFSET, 32'h6000_0000);
      bus(1, CTRL_OFFSET, 0);
      check(q[31:29], 0);
    end
  endtask
  task automatic t_quiet_sniff;
    int i0, s0;
    sniffEnable <= 1'b1;
    for (int ch = 3; ch < 8; ch += 4) begin
      sniffChannel <= 4'(ch);
      i0 = irqs;
      s0 = sniffs;
      run(cw(PACE_ALWAYS, SIZE_WORD, 4'h7, 32'h30 | (1 << QUIET_BIT) | (1 << SNIFF_BIT)), 2, 32'h1000, 32'h2000);
      settle();
      check({irqs - i0, sniffs - s0}, {32'h0, (ch == 7) ? 32'h2 : 32'h0});
      check(sniffData, (ch == 7) ? 32'h4433_3215 : 32'h0);
      bus(0, CTRL_OFFSET, 32'h0);
      repeat (3) @(posedge ref_clk);
      check(irqs - i0, 1);
    end
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_copy();
    t_ring();
    t_pace();
    t_pause();
    t_error();
    t_quiet_sniff();
    complete_run();
  end
endmodule

// *** verilog/dma_ch_pkg.sv ***
// Package for one DMA channel's control and status logic.
// Assumes a single clock domain and an AXI4-Lite register bus.
package dma_ch_pkg;

  // Register byte offsets
  localparam logic [11:0] READ_ADDR_OFFSET = 12'h1c0;
  localparam logic [11:0] WRITE_ADDR_OFFSET = 12'h1c4;
  localparam logic [11:0] TRANS_COUNT_OFFSET = 12'h1c8;
  localparam logic [11:0] CTRL_OFFSET = 12'h1cc;

  // Control and status field positions
  localparam int AGG_ERR_BIT = 31;
  localparam int READ_ERR_BIT = 30;
  localparam int WRITE_ERR_BIT = 29;
  localparam int BUSY_BIT = 24;
  localparam int SNIFF_BIT = 23;
  localparam int REVERSE_BIT = 22;
  localparam int QUIET_BIT = 21;
  localparam int PACE_LSB = 15;
  localparam int NEXT_LSB = 11;
  localparam int RING_SEL_BIT = 10;
  localparam int RING_SIZE_LSB = 6;
  localparam int WRITE_ADV_BIT = 5;
  localparam int READ_ADV_BIT = 4;
  localparam int SIZE_LSB = 2;
  localparam int PRIORITY_BIT = 1;
  localparam int ENABLE_BIT = 0;

  // Reset values and own channel number
  localparam logic [23:0] CTRL_RESET = 24'h003800;
  localparam logic [3:0] OWN_CHANNEL = 4'h7;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

  // Pacing codes
  localparam logic [5:0] PACE_LAST_PERIPHERAL_DATA_REQUEST = 6'h3a;
  localparam logic [5:0] PACE_TIMER0 = 6'h3b;
  localparam logic [5:0] PACE_TIMER3 = 6'h3e;
  localparam logic [5:0] PACE_ALWAYS = 6'h3f;

  // Transfer widths
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } engine_e;

  // Memory request carrier
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [1:0] size;
    logic [31:0] data;
  } mem_req_s;

  // Memory response carrier
  typedef struct packed {
    logic done;
    logic err;
    logic [31:0] data;
  } mem_rsp_s;

endpackage

// *** verilog/dma_channel_control_status.sv ***
// Control, status and a minimal transfer engine for DMA channel 7.
// Assumes memory responses and pacing inputs come from logic on ref_clk.
//
// Summary of operation
// - Bit 31 reads OR of both errors
// - Bus error halts channel, always interrupts
// - Bit 30 set on read error, W1C
// - Read pointer within 0..3 transfers of fault
// - Bit 29 set on write error, W1C
// - Write pointer within 0..5 transfers of fault
// - Busy rises on start, falls at end
// - Disable while busy pauses, busy stays
// - Tap feeds checksum when selected and enabled
// - Byte reversal per transfer width
// - Quiet mode: interrupt on null trigger or bus error
// - Pacing codes select request, 0x3f permanent
// - Codes 0x3b..0x3e select timers 0..3
// - Completion triggers next channel unless self
// - Wrap select picks read or write
// - Wrap size n keeps upper bits fixed
// - Write advance bit steps write pointer
// - Read advance bit steps read pointer
// - Width field: byte, halfword, word steps
// - Preferred flag offered to issue scheduler
// - Preferred flag never touches bus priority
// - Enable gates triggers and transfer issue
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps

module dma_channel_control_status #(
  parameter int PERIPHERAL_DATA_REQUEST_COUNT = 59,
  parameter bit HAS_TIMER23 = 1'b1,
  parameter int COUNT_WIDTH = 32
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // AXI4-Lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pacing sources
  input wire logic [PERIPHERAL_DATA_REQUEST_COUNT-1:0] peripheralDataRequest,
  input wire logic [3:0] timerRequest,
  // Chaining
  input wire logic chainTriggerIn,
  output logic [15:0] chainTriggerOut,
  // Memory side
  output dma_ch_pkg::mem_req_s readReq,
  input wire dma_ch_pkg::mem_rsp_s readRsp,
  output dma_ch_pkg::mem_req_s writeReq,
  input wire dma_ch_pkg::mem_rsp_s writeRsp,
  // Checksum tap
  input wire logic sniffEnable,
  input wire logic [3:0] sniffChannel,
  output logic sniffValid,
  output logic [31:0] sniffData,
  // Scheduler and interrupt
  output logic preferred,
  output logic channelIrq,
  output logic busy
);
  import dma_ch_pkg::*;

  typedef struct packed {
    logic [23:0] ctrl;
    logic readErr;
    logic writeErr;
    logic busy;
    engine_e st;
    logic [31:0] readPtr;
    logic [31:0] writePtr;
    logic [COUNT_WIDTH-1:0] countReload;
    logic [COUNT_WIDTH-1:0] remaining;
    logic [31:0] dataHold;
    mem_req_s rdReq;
    mem_req_s wrReq;
    logic awHeld;
    logic [11:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [15:0] chainOut;
    logic sniffValid;
    logic [31:0] sniffData;
    logic irq;
  } state_s;

  state_s s_q;
  state_s s_d;

  logic paceReq;
  logic [5:0] paceCode;
  logic [31:0] strobeMask;
  logic [31:0] ctrlView;

  // Next pointer value, honouring width, advance and wrap
  function automatic logic [31:0] stepAddr(
    input logic [31:0] addr,
    input logic [1:0] size,
    input logic advance,
    input logic ringOn,
    input logic [3:0] ringSize
  );
    logic [31:0] step;
    logic [31:0] sum;
    logic [31:0] mask;
    step = 32'h0000_0001 << size;
    sum = addr + step;
    mask = (32'h0000_0001 << ringSize) - 32'h0000_0001;
    if (!advance) begin
      stepAddr = addr;
    end else if (ringOn && ringSize != 4'h0) begin
      stepAddr = (addr & ~mask) | (sum & mask);
    end else begin
      stepAddr = sum;
    end
  endfunction

  // Lane ordering for the written data
  function automatic logic [31:0] reorder(input logic [31:0] d, input logic [1:0] size, input logic rev);
    if (!rev || size == SIZE_BYTE) begin
      reorder = d;
    end else if (size == SIZE_HALF) begin
      reorder = {d[31:16], d[7:0], d[15:8]};
    end else begin
      reorder = {d[7:0], d[15:8], d[23:16], d[31:24]};
    end
  endfunction

  always_comb begin
    paceCode = s_q.ctrl[PACE_LSB +: 6];
    paceReq = 1'b0;
    if (paceCode <= PACE_LAST_PERIPHERAL_DATA_REQUEST) begin
      if (int'(paceCode) < PERIPHERAL_DATA_REQUEST_COUNT) begin
        paceReq = peripheralDataRequest[paceCode];
      end
    end else if (paceCode == PACE_ALWAYS) begin
      paceReq = 1'b1;
    end else if (paceCode <= PACE_TIMER3) begin
      // Timers 2 and 3 optional; absent ones never request
      if (HAS_TIMER23 || paceCode <= PACE_TIMER0 + 6'h1) begin
        paceReq = timerRequest[2'(paceCode - PACE_TIMER0)];
      end
    end
  end

  assign ctrlView = {s_q.readErr | s_q.writeErr, s_q.readErr, s_q.writeErr, 4'h0, s_q.busy, s_q.ctrl};

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      strobeMask[i*8 +: 8] = {8{s_q.wStrb[i]}};
    end
  end

  always_comb begin
    logic trig;
    logic nullTrig;
    logic doWrite;
    logic [31:0] merged;
    trig = 1'b0;
    nullTrig = 1'b0;
    doWrite = s_q.awHeld && s_q.wHeld && !s_q.bValid;
    merged = 32'h0000_0000;
    s_d = s_q;
    s_d.chainOut = 16'h0000;
    s_d.sniffValid = 1'b0;
    s_d.irq = 1'b0;

    // Register writes
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.awHeld = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.wHeld = 1'b1;
      s_d.wData = s_axi_wdata;
      s_d.wStrb = s_axi_wstrb;
    end
    if (s_q.bValid && s_axi_bready) begin
      s_d.bValid = 1'b0;
    end
    if (doWrite) begin
      s_d.awHeld = 1'b0;
      s_d.wHeld = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = RESP_OKAY;
      if (s_q.awAddr[11:2] == READ_ADDR_OFFSET[11:2]) begin
        merged = (s_q.readPtr & ~strobeMask) | (s_q.wData & strobeMask);
        s_d.readPtr = merged;
      end else if (s_q.awAddr[11:2] == WRITE_ADDR_OFFSET[11:2]) begin
        merged = (s_q.writePtr & ~strobeMask) | (s_q.wData & strobeMask);
        s_d.writePtr = merged;
      end else if (s_q.awAddr[11:2] == TRANS_COUNT_OFFSET[11:2]) begin
        merged = (32'(s_q.countReload) & ~strobeMask) | (s_q.wData & strobeMask);
        s_d.countReload = COUNT_WIDTH'(merged);
      end else if (s_q.awAddr[11:2] == CTRL_OFFSET[11:2]) begin
        merged = (32'(s_q.ctrl) & ~strobeMask) | (s_q.wData & strobeMask);
        s_d.ctrl = merged[23:0];
        if (s_q.wStrb[3] && s_q.wData[READ_ERR_BIT]) begin
          s_d.readErr = 1'b0;
        end
        if (s_q.wStrb[3] && s_q.wData[WRITE_ERR_BIT]) begin
          s_d.writeErr = 1'b0;
        end
        // Writing the control word is itself a trigger
        if (s_q.wData == 32'h0000_0000 && s_q.wStrb == 4'hf) begin
          nullTrig = 1'b1;
        end else begin
          trig = 1'b1;
        end
      end else begin
        s_d.bResp = RESP_SLVERR;
      end
    end

    // Register reads
    if (s_q.rValid && s_axi_rready) begin
      s_d.rValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rValid = 1'b1;
      s_d.rResp = RESP_OKAY;
      if (s_axi_araddr[11:2] == READ_ADDR_OFFSET[11:2]) begin
        s_d.rData = s_q.readPtr;
      end else if (s_axi_araddr[11:2] == WRITE_ADDR_OFFSET[11:2]) begin
        s_d.rData = s_q.writePtr;
      end else if (s_axi_araddr[11:2] == TRANS_COUNT_OFFSET[11:2]) begin
        s_d.rData = 32'(s_q.remaining);
      end else if (s_axi_araddr[11:2] == CTRL_OFFSET[11:2]) begin
        s_d.rData = ctrlView;
      end else begin
        s_d.rData = 32'h0000_0000;
        s_d.rResp = RESP_SLVERR;
      end
    end

    // null trigger ends a quiet chain
    if (nullTrig && s_q.ctrl[QUIET_BIT]) begin
      s_d.irq = 1'b1;
    end

    // busy rises on a new sequence
    if ((trig || chainTriggerIn) && s_d.ctrl[ENABLE_BIT] && !s_q.busy) begin
      s_d.busy = 1'b1;
      s_d.remaining = s_d.countReload;
    end

    case (s_q.st)
      ST_IDLE: begin
        // paused channel keeps busy, issues nothing
        if (s_q.busy && s_q.ctrl[ENABLE_BIT]) begin
          if (s_q.remaining == '0) begin
            s_d.busy = 1'b0;
            s_d.irq = !s_q.ctrl[QUIET_BIT];
            if (s_q.ctrl[NEXT_LSB +: 4] != OWN_CHANNEL) begin
              s_d.chainOut[s_q.ctrl[NEXT_LSB +: 4]] = 1'b1;
            end
          end else if (paceReq) begin
            s_d.st = ST_READ;
            s_d.rdReq.valid = 1'b1;
            s_d.rdReq.addr = s_q.readPtr;
            s_d.rdReq.size = s_q.ctrl[SIZE_LSB +: 2];
            s_d.rdReq.data = 32'h0000_0000;
          end
        end
      end
      ST_READ: begin
        if (readRsp.done) begin
          s_d.rdReq.valid = 1'b0;
          if (readRsp.err) begin
            // pointer left at the faulting address
            s_d.readErr = 1'b1;
            s_d.busy = 1'b0;
            s_d.irq = 1'b1;
            s_d.st = ST_IDLE;
          end else begin
            // wrap on reads when select is 0
            s_d.readPtr = stepAddr(s_q.readPtr, s_q.ctrl[SIZE_LSB +: 2], s_q.ctrl[READ_ADV_BIT],
                                   !s_q.ctrl[RING_SEL_BIT], s_q.ctrl[RING_SIZE_LSB +: 4]);
            s_d.dataHold = reorder(readRsp.data, s_q.ctrl[SIZE_LSB +: 2], s_q.ctrl[REVERSE_BIT]);
            s_d.wrReq.valid = 1'b1;
            s_d.wrReq.addr = s_q.writePtr;
            s_d.wrReq.size = s_q.ctrl[SIZE_LSB +: 2];
            s_d.wrReq.data = reorder(readRsp.data, s_q.ctrl[SIZE_LSB +: 2], s_q.ctrl[REVERSE_BIT]);
            s_d.st = ST_WRITE;
          end
        end
      end
      ST_WRITE: begin
        if (writeRsp.done) begin
          s_d.wrReq.valid = 1'b0;
          s_d.st = ST_IDLE;
          if (writeRsp.err) begin
            // pointer left at the faulting address
            s_d.writeErr = 1'b1;
            s_d.busy = 1'b0;
            s_d.irq = 1'b1;
          end else begin
            // wrap keeps the upper address bits
            s_d.writePtr = stepAddr(s_q.writePtr, s_q.ctrl[SIZE_LSB +: 2], s_q.ctrl[WRITE_ADV_BIT],
                                    s_q.ctrl[RING_SEL_BIT], s_q.ctrl[RING_SIZE_LSB +: 4]);
            s_d.remaining = s_q.remaining - COUNT_WIDTH'(1);
            if (s_q.ctrl[SNIFF_BIT] && sniffEnable && sniffChannel == OWN_CHANNEL) begin
              s_d.sniffValid = 1'b1;
              s_d.sniffData = s_q.dataHold;
            end
          end
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RESET;
      s_q.st <= ST_IDLE;
      s_q.readPtr <= ADDR_RESET;
      s_q.writePtr <= ADDR_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Ready only while the one-deep holding slot is free
  assign s_axi_awready = !s_q.awHeld && !s_q.bValid;
  assign s_axi_wready = !s_q.wHeld && !s_q.bValid;
  assign s_axi_arready = !s_q.rValid;
  assign s_axi_bvalid = s_q.bValid;
  assign s_axi_bresp = s_q.bResp;
  assign s_axi_rvalid = s_q.rValid;
  assign s_axi_rdata = s_q.rData;
  assign s_axi_rresp = s_q.rResp;

  assign readReq = s_q.rdReq;
  assign writeReq = s_q.wrReq;
  assign chainTriggerOut = s_q.chainOut;
  assign sniffValid = s_q.sniffValid;
  assign sniffData = s_q.sniffData;
  // preferred flag to the issue scheduler
  assign preferred = s_q.ctrl[PRIORITY_BIT];
  assign channelIrq = s_q.irq;
  assign busy = s_q.busy;

endmodule
